//--- hdl/atc_core.v
// Adaptive touch threshold calibration with APB registers and interrupt.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "atc_regs.vh"
module atc_core (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        sample_valid,
    input  wire [1:0]  sample_stage,
    input  wire [15:0] sample_data,
    output reg         int_n,
    output reg  [3:0]  pos_active,
    output reg  [3:0]  neg_active
);
    reg  [15:0] amb_q   [0:3];
    reg  [15:0] offh_q  [0:3];
    reg  [15:0] offl_q  [0:3];
    reg  [15:0] clph_q  [0:3];
    reg  [15:0] clpl_q  [0:3];
    reg  [15:0] sens_q  [0:3];
    reg  [15:0] max_q   [0:3];
    reg  [15:0] min_q   [0:3];
    reg         adapt_q;
    reg  [7:0]  stat_q;
    reg  [7:0]  mask_q;
    reg  [3:0]  actp_q;
    reg  [3:0]  actn_q;
    integer     i_amb;
    integer     i_pk;
    integer     i_off;
    integer     i_clp;
    integer     i_sens;

    wire        setup    = psel & ~penable;
    wire        wr_fire  = psel & penable & pready & pwrite;
    wire        stg_hit  = paddr[`ATC_STG_BASE_BIT];
    wire [1:0]  rstg     = paddr[6:5];
    wire [2:0]  rfld     = paddr[4:2];
    wire [7:0]  waddr    = {paddr[7:2], 2'b00};
    wire        ctrl_hit = (waddr == `ATC_CTRL_OFF);
    wire        stat_hit = (waddr == `ATC_STAT_OFF);
    wire        mask_hit = (waddr == `ATC_MASK_OFF);
    wire        act_hit  = (waddr == `ATC_ACT_OFF);
    wire        glob_hit = ctrl_hit | stat_hit | mask_hit | act_hit;
    wire        mapped   = stg_hit | glob_hit;
    wire        wr_glob  = wr_fire & glob_hit;
    wire        wr_stg   = wr_fire & stg_hit;

    wire [1:0]  s        = sample_stage;
    wire [15:0] amb_s    = amb_q[s];
    wire [15:0] max_s    = max_q[s];
    wire [15:0] min_s    = min_q[s];
    wire [15:0] sens_s   = sens_q[s];
    wire [15:0] hi_s;
    wire [15:0] lo_s;
    wire [15:0] hi_r;
    wire [15:0] lo_r;

    // Thresholds follow the offsets combinationally, so any offset change is seen at once.
    atc_thresh u_thr_smp (
        .amb      (amb_s),
        .offh     (offh_q[s]),
        .offl     (offl_q[s]),
        .pos_code (sens_s[3:0]),
        .neg_code (sens_s[7:4]),
        .hi       (hi_s),
        .lo       (lo_s)
    );

    atc_thresh u_thr_rd (
        .amb      (amb_q[rstg]),
        .offh     (offh_q[rstg]),
        .offl     (offl_q[rstg]),
        .pos_code (sens_q[rstg][3:0]),
        .neg_code (sens_q[rstg][7:4]),
        .hi       (hi_r),
        .lo       (lo_r)
    );

    // Contact is judged against ambient-referenced thresholds.
    wire        touch_p  = sample_data > hi_s;
    wire        touch_n  = sample_data < lo_s;
    wire        untouched = ~touch_p & ~touch_n;

    // Slow averaging of the untouched level.
    wire [16:0] adiff    = {1'b0, sample_data} - {1'b0, amb_s};
    wire [16:0] astep    = $signed(adiff) >>> `ATC_AMB_SHIFT;
    wire [15:0] amb_new  = amb_s + astep[15:0];

    // Peak gating windows, percentages in sixteenths of the span.
    wire [15:0] span_p   = (max_s > amb_s) ? max_s - amb_s : 16'h0000;
    wire [15:0] span_n   = (amb_s > min_s) ? amb_s - min_s : 16'h0000;
    wire [19:0] win_p20  = {4'h0, span_p} * {16'h0000, sens_s[11:8]};
    wire [19:0] win_n20  = {4'h0, span_n} * {16'h0000, sens_s[15:12]};
    wire [15:0] win_p    = win_p20[19:4];
    wire [15:0] win_n    = win_n20[19:4];
    wire        gate_p   = (sample_data > amb_s) &
                           ({1'b0, sample_data} + {1'b0, win_p} >= {1'b0, max_s});
    wire        gate_n   = (sample_data < amb_s) &
                           ({1'b0, min_s} + {1'b0, win_n} >= {1'b0, sample_data});
    wire [16:0] max_sum  = {1'b0, max_s} + {1'b0, sample_data};
    wire [16:0] min_sum  = {1'b0, min_s} + {1'b0, sample_data};
    wire [15:0] max_new  = (sample_data > max_s) ? max_sum[16:1] :
                           ((max_s > amb_s) ? max_sum[16:1] : sample_data);
    wire [15:0] min_new  = (sample_data < min_s) ? min_sum[16:1] :
                           ((min_s < amb_s) ? min_sum[16:1] : sample_data);

    // Offsets chase the measured response span around the drifting ambient.
    wire [15:0] offh_nxt;
    wire [15:0] offl_nxt;
    atc_step u_step_h (
        .cur    (offh_q[s]),
        .target (span_p),
        .clamp  (clph_q[s]),
        .nxt    (offh_nxt)
    );
    atc_step u_step_l (
        .cur    (offl_q[s]),
        .target (span_n),
        .clamp  (clpl_q[s]),
        .nxt    (offl_nxt)
    );

    wire        do_comp  = sample_valid & untouched;
    wire        do_adapt = do_comp & adapt_q;

    // Activation change events, positive in the low nibble and negative in the high one.
    reg  [7:0]  ev_d;
    reg  [7:0]  clr_d;
    reg  [7:0]  stat_d;
    always @* begin
        ev_d = 8'h00;
        if (sample_valid) begin
            ev_d[s]     = touch_p ^ actp_q[s];
            ev_d[s + 4] = touch_n ^ actn_q[s];
        end
        clr_d = 8'h00;
        if (wr_glob & stat_hit) begin
            clr_d = pwdata[7:0];
        end
        stat_d = (stat_q & ~clr_d) | ev_d;
    end

    // Read data mux, sampled in the setup phase.
    reg  [31:0] rd_d;
    always @* begin
        rd_d = 32'h00000000;
        if (stg_hit) begin
            case (rfld)
                `ATC_F_OFFH: rd_d = {16'h0000, offh_q[rstg]};
                `ATC_F_OFFL: rd_d = {16'h0000, offl_q[rstg]};
                `ATC_F_CLPH: rd_d = {16'h0000, clph_q[rstg]};
                `ATC_F_CLPL: rd_d = {16'h0000, clpl_q[rstg]};
                `ATC_F_SENS: rd_d = {16'h0000, sens_q[rstg]};
                `ATC_F_AMB:  rd_d = {16'h0000, amb_q[rstg]};
                `ATC_F_HI:   rd_d = {16'h0000, hi_r};
                `ATC_F_LO:   rd_d = {16'h0000, lo_r};
                default:     rd_d = 32'h00000000;
            endcase
        end else if (glob_hit) begin
            case (paddr[3:2])
                2'h0:    rd_d = {31'h00000000, adapt_q};
                2'h1:    rd_d = {24'h000000, stat_q};
                2'h2:    rd_d = {24'h000000, mask_q};
                2'h3:    rd_d = {24'h000000, actn_q, actp_q};
                default: rd_d = 32'h00000000;
            endcase
        end
    end

    // Access phase never waits, so pready is the registered setup strobe.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // Unmapped addresses are refused with an error and zero data.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup & ~mapped;
        end
    end

    // Read data is taken in the setup cycle and holds until the next setup.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup) begin
            prdata <= mapped ? rd_d : 32'h00000000;
        end
    end

    // Adaptive threshold enable.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adapt_q <= `ATC_CTRL_RST;
        end else if (wr_glob & ctrl_hit) begin
            adapt_q <= pwdata[`ATC_CTRL_ADAPT];
        end
    end

    // Sticky status; an event in the cycle of its clear keeps the bit set.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= `ATC_STAT_RST;
        end else begin
            stat_q <= stat_d;
        end
    end

    // Interrupt mask, same layout as the status.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= `ATC_MASK_RST;
        end else if (wr_glob & mask_hit) begin
            mask_q <= pwdata[7:0];
        end
    end

    // Positive activation per stage.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            actp_q <= 4'h0;
        end else if (sample_valid) begin
            actp_q[s] <= touch_p;
        end
    end

    // Negative activation per stage.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            actn_q <= 4'h0;
        end else if (sample_valid) begin
            actn_q[s] <= touch_n;
        end
    end

    // Level interrupt, low while an unmasked status bit is set.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_n <= 1'b1;
        end else begin
            int_n <= ~|(stat_q & mask_q);
        end
    end

    // Registered activation outputs.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_active <= 4'h0;
            neg_active <= 4'h0;
        end else begin
            pos_active <= actp_q;
            neg_active <= actn_q;
        end
    end

    // Ambient follows untouched samples; a host write in the same cycle wins.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i_amb = 0; i_amb < `ATC_NST; i_amb = i_amb + 1) begin
                amb_q[i_amb] <= `ATC_AMB_RST;
            end
        end else begin
            if (do_comp) begin
                amb_q[s] <= amb_new;
            end
            if (wr_stg & (rfld == `ATC_F_AMB)) begin
                amb_q[rstg] <= pwdata[15:0];
            end
        end
    end

    // Peak averages, each updated only inside its gate.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i_pk = 0; i_pk < `ATC_NST; i_pk = i_pk + 1) begin
                max_q[i_pk] <= `ATC_MAX_RST;
                min_q[i_pk] <= `ATC_MIN_RST;
            end
        end else begin
            if (sample_valid & gate_p) begin
                max_q[s] <= max_new;
            end
            if (sample_valid & gate_n) begin
                min_q[s] <= min_new;
            end
        end
    end

    // Drift offsets step with calibration; a host write in the same cycle wins.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i_off = 0; i_off < `ATC_NST; i_off = i_off + 1) begin
                offh_q[i_off] <= `ATC_OFF_RST;
                offl_q[i_off] <= `ATC_OFF_RST;
            end
        end else begin
            if (do_adapt) begin
                offh_q[s] <= offh_nxt;
                offl_q[s] <= offl_nxt;
            end
            if (wr_stg & (rfld == `ATC_F_OFFH)) begin
                offh_q[rstg] <= pwdata[15:0];
            end
            if (wr_stg & (rfld == `ATC_F_OFFL)) begin
                offl_q[rstg] <= pwdata[15:0];
            end
        end
    end

    // Clamps are written by the host only.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i_clp = 0; i_clp < `ATC_NST; i_clp = i_clp + 1) begin
                clph_q[i_clp] <= `ATC_CLP_RST;
                clpl_q[i_clp] <= `ATC_CLP_RST;
            end
        end else begin
            if (wr_stg & (rfld == `ATC_F_CLPH)) begin
                clph_q[rstg] <= pwdata[15:0];
            end
            if (wr_stg & (rfld == `ATC_F_CLPL)) begin
                clpl_q[rstg] <= pwdata[15:0];
            end
        end
    end

    // Sensitivity and peak gate codes are written by the host only.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i_sens = 0; i_sens < `ATC_NST; i_sens = i_sens + 1) begin
                sens_q[i_sens] <= `ATC_SENS_RST;
            end
        end else if (wr_stg & (rfld == `ATC_F_SENS)) begin
            sens_q[rstg] <= pwdata[15:0];
        end
    end
endmodule // atc_core
`default_nettype wire

//--- inc/atc_regs.vh
// Register map, field layout and reset values of the adaptive touch threshold block.
// How it works
// - Upper threshold uses quarter offset times sensitivity.
// - Lower threshold adds scaled remainder times sensitivity.
// - Offset changes recompute thresholds with no host.
// - Offsets follow ambient drift per stage.
// - Ambient comes from slow averaging of untouched samples.
// - Minimum average updates only inside negative gate.
// - Maximum average updates only inside positive gate.
// - Clamp values bound the adjusted offsets.
// - Sixteen sensitivity levels per direction.
// - Smaller codes put thresholds nearer ambient.
// - Positive code 1000 gives about 225%.
// - Thresholds reference ambient; contact needs crossing.
// - Adaptive mode rescales from maximum and minimum averages.
// - Compensation runs only while untouched.
// - Active-low interrupt on threshold crossing.
`ifndef ATC_REGS_VH
`define ATC_REGS_VH
`define ATC_NST          4
`define ATC_DW           16
`define ATC_AW           8
`define ATC_CTRL_OFF     8'h00
`define ATC_STAT_OFF     8'h04
`define ATC_MASK_OFF     8'h08
`define ATC_ACT_OFF      8'h0C
`define ATC_STG_BASE_BIT 7
`define ATC_F_OFFH       3'h0
`define ATC_F_OFFL       3'h1
`define ATC_F_CLPH       3'h2
`define ATC_F_CLPL       3'h3
`define ATC_F_SENS       3'h4
`define ATC_F_AMB        3'h5
`define ATC_F_HI         3'h6
`define ATC_F_LO         3'h7
`define ATC_CTRL_ADAPT   0
`define ATC_CTRL_RST     1'h1
`define ATC_STAT_RST     8'h00
`define ATC_MASK_RST     8'h00
`define ATC_AMB_RST      16'h0000
`define ATC_SENS_RST     16'h0000
`define ATC_OFF_RST      16'h0000
`define ATC_CLP_RST      16'hFFFF
`define ATC_MAX_RST      16'h0000
`define ATC_MIN_RST      16'hFFFF
`define ATC_AMB_SHIFT    3
`define ATC_QSHIFT       2
`define ATC_SSHIFT       4
`endif

//--- hdl/atc_thresh.v
// Threshold arithmetic for one stage.
`timescale 1ns/1ps
`default_nettype none
`include "atc_regs.vh"
module atc_thresh (
    input  wire [15:0] amb,
    input  wire [15:0] offh,
    input  wire [15:0] offl,
    input  wire [3:0]  pos_code,
    input  wire [3:0]  neg_code,
    output wire [15:0] hi,
    output wire [15:0] lo
);
    wire [15:0] qh   = offh >> `ATC_QSHIFT;
    wire [15:0] ql   = offl >> `ATC_QSHIFT;
    wire [15:0] rl   = (offl - ql) >> `ATC_SSHIFT;
    wire [19:0] hsum = {4'h0, amb} + {4'h0, qh} + ({4'h0, qh} * {16'h0000, pos_code});
    wire [19:0] lsum = {4'h0, amb} + {4'h0, ql} + ({4'h0, rl} * {16'h0000, neg_code});
    assign hi = (|hsum[19:16]) ? 16'hFFFF : hsum[15:0];
    assign lo = (|lsum[19:16]) ? 16'hFFFF : lsum[15:0];
endmodule // atc_thresh
`default_nettype wire

//--- hdl/atc_step.v
// One-step move of an offset toward a target, bounded by a clamp.
`timescale 1ns/1ps
`default_nettype none
module atc_step (
    input  wire [15:0] cur,
    input  wire [15:0] target,
    input  wire [15:0] clamp,
    output wire [15:0] nxt
);
    wire [15:0] moved = (cur < target) ? cur + 16'h0001 :
                        (cur > target) ? cur - 16'h0001 : cur;
    assign nxt = (moved > clamp) ? clamp : moved;
endmodule // atc_step
`default_nettype wire

//--- testbench/atc_core_asserts.sv
// Port-level checks on the adaptive touch threshold core.
`timescale 1ns/1ps
`default_nettype none
module atc_core_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sample_valid,
    input wire logic [1:0]  sample_stage,
    input wire logic [15:0] sample_data,
    input wire logic        int_n,
    input wire logic [3:0]  pos_active,
    input wire logic [3:0]  neg_active
);
    wire        wr_acc = psel && penable && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_hole; s_setup ##0 (paddr >= 8'h10 && paddr < 8'h80); endsequence
    property p_ready; s_setup |=> pready; endproperty
    property p_pulse; pready |=> !pready; endproperty
    property p_err; pslverr |-> pready; endproperty
    property p_hole; s_hole |=> pslverr && prdata == 32'h0; endproperty
    property p_map; s_setup ##0 (paddr < 8'h10 || paddr >= 8'h80) |=> !pslverr; endproperty
    property p_fall; $fell(int_n) |-> $past(sample_valid, 2) || $past(wr_acc, 2);
    endproperty
    property p_rise; $rose(int_n) |-> $past(wr_acc, 2); endproperty
    property p_act; (pos_active != $past(pos_active) || neg_active != $past(neg_active))
        |-> $past(sample_valid) || $past(sample_valid, 2); endproperty
    a_ready: assert property (p_ready) else $error("pready missing after setup");
    a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
    a_err: assert property (p_err) else $error("pslverr without pready");
    a_hole: assert property (p_hole) else $error("unmapped access not refused");
    a_map: assert property (p_map) else $error("mapped access refused");
    a_fall: assert property (p_fall) else $error("interrupt without cause");
    a_rise: assert property (p_rise) else $error("interrupt dropped without write");
    a_act: assert property (p_act) else $error("activation changed without sample");
endmodule // atc_core_asserts
bind atc_core atc_core_asserts atc_core_asserts_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
    .sample_stage(sample_stage), .sample_data(sample_data), .int_n(int_n),
    .pos_active(pos_active), .neg_active(neg_active));
`default_nettype wire

//--- testbench/atc_core_test.sv
// Self-checking bench for the adaptive touch threshold core.
`timescale 1ns/1ps
`default_nettype none
`include "atc_regs.vh"
module atc_core_test;
    logic        pclk, presetn, psel, penable, pwrite, sample_valid, pready, pslverr, int_n;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  sample_stage;
    logic [15:0] sample_data;
    logic [3:0]  pos_active, neg_active;
    int          miscompares, compares, k;
    atc_core atc_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sample_valid), .sample_stage(sample_stage),
        .sample_data(sample_data), .int_n(int_n), .pos_active(pos_active),
        .neg_active(neg_active));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk("pready_wait", n, 32'h00000001);
        chk("pslverr", {31'h0, pslverr}, {31'h0, e});
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 1'b0);
        chk(nm, rd, exp);
    endtask
    task automatic smp(input logic [1:0] s, input logic [15:0] d);
        @(posedge pclk);
        sample_valid <= 1'b1;
        sample_stage <= s;
        sample_data <= d;
        @(posedge pclk);
        sample_valid <= 1'b0;
        @(posedge pclk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        #2000000;
        miscompares++;
        report_and_stop;
    end
    initial begin
        {presetn, psel, penable, pwrite, sample_valid} = 5'h0;
        {paddr, pwdata, sample_stage, sample_data} = 58'h0;
        miscompares = 0;
        compares = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("ctrl", `ATC_CTRL_OFF, 32'h00000001);
        rdchk("clamp", 8'h88, 32'h0000FFFF);
        apb(1'b1, 8'h40, 32'h00000005, 1'b1);
        apb(1'b1, `ATC_CTRL_OFF, 32'h00000000, 1'b0);
        apb(1'b1, 8'h94, 32'h00001000, 1'b0);
        apb(1'b1, 8'h80, 32'h00000402, 1'b0);
        apb(1'b1, 8'h84, 32'h0000030E, 1'b0);
        for (k = 0; k < 16; k++) begin
            apb(1'b1, 8'h90, {24'h0, k[3:0], k[3:0]}, 1'b0);
            rdchk("hi", 8'h98, 32'h1000 + 32'h100 * (k + 1));
            rdchk("lo", 8'h9C, 32'h10C3 + 32'h24 * k);
        end
        apb(1'b1, 8'h80, 32'h00000800, 1'b0);
        rdchk("hi_new", 8'h98, 32'h00003000);
        apb(1'b1, `ATC_MASK_OFF, 32'h00000001, 1'b0);
        smp(2'h0, 16'hFFF0);
        chk("pos", {28'h0, pos_active}, 32'h1);
        chk("int_n", {31'h0, int_n}, 32'h0);
        rdchk("stat", `ATC_STAT_OFF, 32'h00000001);
        apb(1'b1, `ATC_STAT_OFF, 32'h00000001, 1'b0);
        @(posedge pclk);
        #1;
        chk("int_clr", {31'h0, int_n}, 32'h1);
        apb(1'b1, 8'hB4, 32'h00001000, 1'b0);
        smp(2'h1, 16'h0010);
        chk("neg", {28'h0, neg_active}, 32'h2);
        chk("int_mask", {31'h0, int_n}, 32'h1);
        rdchk("act", `ATC_ACT_OFF, 32'h00000021);
        smp(2'h0, 16'h2000);
        chk("release", {28'h0, pos_active}, 32'h0);
        chk("int_rel", {31'h0, int_n}, 32'h0);
        rdchk("stat2", `ATC_STAT_OFF, 32'h00000021);
        rdchk("amb0", 8'h94, 32'h00001200);
        rdchk("offh_hold", 8'h80, 32'h00000800);
        apb(1'b1, 8'hC8, 32'h00000005, 1'b0);
        apb(1'b1, 8'hCC, 32'h00000005, 1'b0);
        apb(1'b1, 8'hC0, 32'h00000004, 1'b0);
        apb(1'b1, 8'hC4, 32'h00000004, 1'b0);
        apb(1'b1, 8'hD0, 32'h00000000, 1'b0);
        apb(1'b1, 8'hD4, 32'h00001000, 1'b0);
        apb(1'b1, `ATC_CTRL_OFF, 32'h00000001, 1'b0);
        smp(2'h2, 16'h3000);
        rdchk("amb_touch", 8'hD4, 32'h00001000);
        rdchk("offh_touch", 8'hC0, 32'h00000004);
        smp(2'h2, 16'h1001);
        rdchk("offh_up", 8'hC0, 32'h00000005);
        rdchk("offl_down", 8'hC4, 32'h00000003);
        smp(2'h2, 16'h1001);
        rdchk("offh_clamp", 8'hC0, 32'h00000005);
        rdchk("offl_down2", 8'hC4, 32'h00000002);
        report_and_stop;
    end
endmodule // atc_core_test
`default_nettype wire
